/* File: logic/fbwp_protect.v */
// The implementer's own choices: the register addresses and the address-and-strobe port.
`include "fbwp_regs.vh"
`default_nettype none
// ****************************************************************
// block write protection, status lock and pin remapping
// ****************************************************************
module fbwp_protect #(
  parameter BLOCK_BITS = 10
) (
  input  wire        clock,
  input  wire        reset_n,
  input  wire        clk_en,
  input  wire [3:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  input  wire        wp_pin_in,
  input  wire        hold_pin_in,
  input  wire [3:0]  io_in,
  output reg         wp_ctrl_low,
  output reg         hold_ctrl_low,
  output reg         io23_oe,
  output reg  [1:0]  io23_in_data,
  output reg         op_start,
  output reg  [7:0]  op_code,
  output reg         op_refused
);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  reg [3:0] wp_sync_r;
  reg [1:0] hold_sync_r;
  wire [1:0] io_hi = io_in[3:2];
  reg [1:0] io_s1_r;
  reg [1:0] io_s2_r;

  // two flops on the protect, hold and io2/io3 pins
  // protect and hold pins idle high, so their stages reset high;
  // a low reset value would fake a protect request just after reset
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wp_sync_r   <= 4'h3;
      hold_sync_r <= 2'h3;
      io_s1_r     <= 2'h0;
      io_s2_r     <= 2'h0;
    end else if (clk_en) begin
      wp_sync_r   <= {2'h0, wp_sync_r[0], wp_pin_in};
      hold_sync_r <= {hold_sync_r[0], hold_pin_in};
      io_s1_r     <= io_hi;
      io_s2_r     <= io_s1_r;
    end
  end
  wire wp_level   = wp_sync_r[1];
  wire hold_level = hold_sync_r[1];

  // ****************************************************************
  // state registers
  // ****************************************************************
  reg [7:0]  status_r;
  reg [7:0]  func_r;
  reg        large_blocks_r;
  reg [1:0]  result_r;
  wire       write_enable_latch    = status_r[`FBWP_ST_WEL];
  wire [3:0] level  = status_r[`FBWP_ST_BP_LO+3:`FBWP_ST_BP_LO];
  wire       qe     = status_r[`FBWP_ST_QE];
  wire       lock   = status_r[`FBWP_ST_LOCK];
  wire       area   = func_r[`FBWP_FN_AREA];

  // ****************************************************************
  // protected range arithmetic
  // ****************************************************************
  // protected block count for the 64KB array
  function [10:0] count_64k;
    input [3:0] lv;
    begin
      case (lv)
        4'hA: count_64k = 11'd512;
        4'hB: count_64k = 11'd768;
        4'hC: count_64k = 11'd896;
        4'hD: count_64k = 11'd960;
        4'hE: count_64k = 11'd992;
        4'hF: count_64k = 11'd1024;
        4'h0: count_64k = 11'd0;
        default: count_64k = 11'd1 << (lv - 4'h1);
      endcase
    end
  endfunction

  // protected block count for the 256KB array
  function [10:0] count_256k;
    input [3:0] lv;
    begin
      if (lv == 4'h0) begin
        count_256k = 11'd0;
      end else if (lv >= 4'h9) begin
        count_256k = 11'd256;
      end else begin
        count_256k = 11'd1 << (lv - 4'h1);
      end
    end
  endfunction

  // block index inside or outside the protected run
  function in_protected;
    input [10:0] blk;
    input [10:0] cnt;
    input [10:0] total;
    input        bottom;
    begin
      if (bottom) begin
        in_protected = blk < cnt;
      end else begin
        in_protected = blk >= (total - cnt);
      end
    end
  endfunction

  // ****************************************************************
  // command decode from the command register write
  // ****************************************************************
  wire        cmd_wr   = reg_wr && (reg_addr == `FBWP_ADDR_COMMAND);
  wire [7:0]  cmd_op   = reg_wdata[31:24];
  wire [23:0] cmd_arg  = reg_wdata[23:0];
  wire [10:0] blk_idx  = large_blocks_r ? {3'h0, cmd_arg[23:16]} : {1'b0, cmd_arg[23:14]};
  wire [10:0] blk_cnt  = large_blocks_r ? count_256k(level) : count_64k(level);
  wire [10:0] blk_tot  = large_blocks_r ? 11'd256 : 11'd1024;
  wire        hit      = in_protected(blk_idx, blk_cnt, blk_tot, area);
  wire        is_mod   = (cmd_op == `FBWP_OP_PP) || (cmd_op == `FBWP_OP_SE)
                         || (cmd_op == `FBWP_OP_BE64);
  wire        is_cer   = (cmd_op == `FBWP_OP_CER_A) || (cmd_op == `FBWP_OP_CER_B);
  wire        sr_free  = !lock || wp_level || qe;    // (with quad on, pin is data)
  wire        no_write_enable_cmd  = (cmd_op == `FBWP_OP_SET_READ_PARAMS_VOLATILE_NW) || (cmd_op == `FBWP_OP_WRITE_BANK_ADDR_VOLATILE_NW);
  wire        needs_we = (cmd_op == `FBWP_OP_SET_READ_PARAMS_VOLATILE) || (cmd_op == `FBWP_OP_WRITE_BANK_ADDR_VOLATILE);
  reg         accept;

  // ****************************************************************
  // instruction acceptance
  // ****************************************************************
  // acceptance of an issued instruction
  always @* begin
    accept = 1'b0;
    if (no_write_enable_cmd) begin
      accept = 1'b1;
    end else if (needs_we) begin
      accept = write_enable_latch;
    end else if (cmd_op == `FBWP_OP_WRITE_STATUS_CMD) begin
      accept = write_enable_latch && sr_free;
    end else if (cmd_op == `FBWP_OP_WRFR) begin
      accept = write_enable_latch;
    end else if (is_cer) begin
      accept = write_enable_latch && (level == 4'h0);
    end else if (is_mod) begin
      accept = write_enable_latch && !hit;
    end else if ((cmd_op == `FBWP_OP_WRITE_ENABLE_CMD) || (cmd_op == `FBWP_OP_WRDI)) begin
      accept = 1'b1;
    end
  end

  wire shadow_wr = cmd_wr && accept && (no_write_enable_cmd || needs_we);
  wire shadow_sel = (cmd_op == `FBWP_OP_WRITE_BANK_ADDR_VOLATILE_NW) || (cmd_op == `FBWP_OP_WRITE_BANK_ADDR_VOLATILE);
  wire [7:0] shadow_q;

  fbwp_shadow_mem #(
    .WIDTH (8),
    .DEPTH (2)
  ) u_shadow (
    .clock   (clock),
    .reset_n (reset_n),
    .clk_en  (clk_en),
    .wr_en   (shadow_wr),
    .wr_addr (shadow_sel),
    .wr_data (cmd_arg[7:0]),
    .rd_addr (reg_addr[0]),
    .rd_data (shadow_q)
  );

  // ****************************************************************
  // register updates
  // ****************************************************************
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      status_r       <= `FBWP_ST_RESET;
      func_r         <= `FBWP_FN_RESET;
      large_blocks_r <= 1'b0;
      result_r       <= 2'h0;
      op_start       <= 1'b0;
      op_code        <= 8'h00;
      op_refused     <= 1'b0;
    end else if (clk_en) begin
      op_start   <= 1'b0;
      op_refused <= 1'b0;
      if (reg_wr && (reg_addr == `FBWP_ADDR_CONFIG)) begin
        large_blocks_r <= reg_wdata[0];
      end
      if (cmd_wr) begin
        op_code    <= cmd_op;
        op_start   <= accept;
        op_refused <= !accept;
        result_r   <= accept ? `FBWP_RES_DONE : `FBWP_RES_REFUSED;
        if (accept) begin
          if (cmd_op == `FBWP_OP_WRITE_ENABLE_CMD) begin
            status_r[`FBWP_ST_WEL] <= 1'b1;
          end else if (cmd_op == `FBWP_OP_WRDI) begin
            status_r[`FBWP_ST_WEL] <= 1'b0;
          end else if (cmd_op == `FBWP_OP_WRITE_STATUS_CMD) begin
            // lock, quad and level bits; write latch cleared after use
            status_r <= {cmd_arg[7:2], 2'h0};
          end else if (cmd_op == `FBWP_OP_WRFR) begin
            // one-time bits only move from zero to one
            func_r[7:4] <= func_r[7:4] | cmd_arg[7:4];
            func_r[1]   <= func_r[1] | cmd_arg[1];
            func_r[0]   <= func_r[0] | cmd_arg[0];
            status_r[`FBWP_ST_WEL] <= 1'b0;
          end else if (!no_write_enable_cmd) begin
            status_r[`FBWP_ST_WEL] <= 1'b0;
          end
        end
      end
    end
  end

  // ****************************************************************
  // pin function mapping
  // ****************************************************************
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wp_ctrl_low   <= 1'b0;
      hold_ctrl_low <= 1'b0;
      io23_oe       <= 1'b0;
      io23_in_data  <= 2'h0;
    end else if (clk_en) begin
      // pin functions follow the second sync stage
      wp_ctrl_low   <= !qe && !wp_level;
      hold_ctrl_low <= !qe && !hold_level;
      io23_oe       <= 1'b0;                 // never driven by this block
      io23_in_data  <= qe ? io_s2_r : 2'h0;
    end
  end

  // ****************************************************************
  // register read port, data one cycle after strobe
  // ****************************************************************
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (clk_en) begin
      if (!reg_rd) begin
        reg_rdata <= 32'h0000_0000;
      end else if (reg_addr == `FBWP_ADDR_STATUS) begin
        reg_rdata <= {24'h000000, status_r};
      end else if (reg_addr == `FBWP_ADDR_FUNCTION) begin
        reg_rdata <= {24'h000000, func_r};
      end else if (reg_addr == `FBWP_ADDR_RESULT) begin
        reg_rdata <= {30'h0, result_r};
      end else if (reg_addr == `FBWP_ADDR_CONFIG) begin
        reg_rdata <= {31'h0, large_blocks_r};
      end else begin
        reg_rdata <= 32'h0000_0000;
      end
    end
  end

  // ****************************************************************
  // spare bits
  // ****************************************************************
  // shadow data, spare sync stages and io0/io1 have no reader here
  wire unused_ok = &{shadow_q, wp_sync_r[3:2], io_in[1:0], 1'b0};
endmodule
`default_nettype wire

/* File: logic/fbwp_shadow_mem.v */
`default_nettype none
// ****************************************************************
// small register store for the volatile read and bank parameters
// ****************************************************************
module fbwp_shadow_mem #(
  parameter WIDTH = 8,
  parameter DEPTH = 2
) (
  input  wire                     clock,
  input  wire                     reset_n,
  input  wire                     clk_en,
  input  wire                     wr_en,
  input  wire [0:0]               wr_addr,
  input  wire [WIDTH-1:0]         wr_data,
  input  wire [0:0]               rd_addr,
  output reg  [WIDTH-1:0]         rd_data
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  integer i;

  // store and registered read
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem_r[i] <= {WIDTH{1'b0}};
      end
      rd_data <= {WIDTH{1'b0}};
    end else if (clk_en) begin
      if (wr_en) begin
        mem_r[wr_addr] <= wr_data;
      end
      rd_data <= mem_r[rd_addr];
    end
  end
endmodule
`default_nettype wire

/* File: shared/fbwp_regs.vh */
// Overview of operation
// - volatile read-param and bank writes by 8'hC0 and 8'h17 skip write-enable; 8'h63 and 8'hC5 need it
// - program or erase inside protected area inhibited
// - chip erase only when protect level zero
// - lock bit zero lets status writes through
// - lock set, pin low: status bits frozen (with quad enable set, the pin is data and status writes still pass)
// - lock set, pin high: status writes allowed
// - quad enable turns control pins into data
// - large-block levels 1-9 protect powers of two
// - large-block levels 10-15 protect 512..1024 blocks
// - area select chooses top or bottom end
// - huge-block levels 1-8 protect powers of two
// - huge-block levels 9-15 protect everything
// - function register eight bits, fixed layout
// - bottom area select is permanent
`ifndef FBWP_REGS_VH
`define FBWP_REGS_VH

// ****************************************************************
// register indices on the plain register port
// ****************************************************************
`define FBWP_ADDR_STATUS   4'h0
`define FBWP_ADDR_FUNCTION 4'h1
`define FBWP_ADDR_COMMAND  4'h2
`define FBWP_ADDR_RESULT   4'h3
`define FBWP_ADDR_CONFIG   4'h4

// ****************************************************************
// status register fields
// ****************************************************************
`define FBWP_ST_WEL        1
`define FBWP_ST_BP_LO      2
`define FBWP_ST_QE         6
`define FBWP_ST_LOCK       7
`define FBWP_ST_RESET      8'h00

// ****************************************************************
// function register fields
// ****************************************************************
`define FBWP_FN_RST_DIS    0
`define FBWP_FN_AREA       1
`define FBWP_FN_PROGRAM_SUSPENDED       2
`define FBWP_FN_ERASE_SUSPENDED       3
`define FBWP_FN_IRL_LO     4
`define FBWP_FN_RESET      8'h00

// ****************************************************************
// instruction codes
// ****************************************************************
`define FBWP_OP_WRITE_ENABLE_CMD       8'h06
`define FBWP_OP_WRDI       8'h04
`define FBWP_OP_WRITE_STATUS_CMD       8'h01
`define FBWP_OP_WRFR       8'h42
`define FBWP_OP_CER_A      8'hC7
`define FBWP_OP_CER_B      8'h60
`define FBWP_OP_PP         8'h02
`define FBWP_OP_SE         8'h20
`define FBWP_OP_BE64       8'hD8
`define FBWP_OP_SET_READ_PARAMS_VOLATILE_NW    8'hC0
`define FBWP_OP_WRITE_BANK_ADDR_VOLATILE_NW   8'h17
`define FBWP_OP_SET_READ_PARAMS_VOLATILE       8'h63
`define FBWP_OP_WRITE_BANK_ADDR_VOLATILE      8'hC5

// ****************************************************************
// result codes
// ****************************************************************
`define FBWP_RES_DONE      2'h1
`define FBWP_RES_REFUSED   2'h2

`endif

/* File: verif/fbwp_checker_properties.sv */
`include "fbwp_regs.vh"
`default_nettype none
// ************************************************************
// port checker for the protection block
// ************************************************************
module fbwp_checker (
  input wire logic        clock,
  input wire logic        reset_n,
  input wire logic        clk_en,
  input wire logic [3:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        wp_pin_in,
  input wire logic        hold_pin_in,
  input wire logic        wp_ctrl_low,
  input wire logic        hold_ctrl_low,
  input wire logic        io23_oe,
  input wire logic [1:0]  io23_in_data,
  input wire logic        op_start,
  input wire logic [7:0]  op_code,
  input wire logic        op_refused
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // a command word taken on this edge
  wire cmd_w = reg_wr && clk_en && (reg_addr == `FBWP_ADDR_COMMAND);
  // data lines are only ever inputs here
  property p_oe_off; io23_oe == 1'b0; endproperty
  a_oe_off: assert property (p_oe_off) else $error("io23 driven");
  property p_write_enable_cmd; cmd_w && reg_wdata[31:24] == `FBWP_OP_WRITE_ENABLE_CMD |=> op_start && !op_refused;
  endproperty
  a_write_enable_cmd: assert property (p_write_enable_cmd) else $error("write enable not taken");
  property p_nowren;
    cmd_w && (reg_wdata[31:24] == `FBWP_OP_SET_READ_PARAMS_VOLATILE_NW || reg_wdata[31:24] == `FBWP_OP_WRITE_BANK_ADDR_VOLATILE_NW)
    |=> op_start;
  endproperty
  a_nowren: assert property (p_nowren) else $error("volatile op refused");
  property p_code; cmd_w |=> op_code == $past(reg_wdata[31:24]); endproperty
  a_code: assert property (p_code) else $error("opcode not kept");
  property p_refuse_cause; op_refused |-> $past(cmd_w); endproperty
  a_refuse_cause: assert property (p_refuse_cause) else $error("stray refusal");
  property p_wp_high; wp_pin_in [*4] |-> !wp_ctrl_low; endproperty
  a_wp_high: assert property (p_wp_high) else $error("protect while pin high");
  property p_hold_high; hold_pin_in [*4] |-> !hold_ctrl_low; endproperty
  a_hold_high: assert property (p_hold_high) else $error("hold while pin high");
  property p_quad_excl; io23_in_data != 2'h0 |-> !wp_ctrl_low && !hold_ctrl_low; endproperty
  a_quad_excl: assert property (p_quad_excl) else $error("pins both data and control");
endmodule

bind fbwp_protect fbwp_checker u_chk (
  .clock(clock), .reset_n(reset_n), .clk_en(clk_en), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .wp_pin_in(wp_pin_in), .hold_pin_in(hold_pin_in),
  .wp_ctrl_low(wp_ctrl_low), .hold_ctrl_low(hold_ctrl_low), .io23_oe(io23_oe),
  .io23_in_data(io23_in_data), .op_start(op_start), .op_code(op_code), .op_refused(op_refused)
);
`default_nettype wire

/* File: verif/fbwp_pin_model.sv */
`default_nettype none
// ************************************************************
// host side of the protect, hold and data pins
// ************************************************************
module fbwp_pin_model (
  input  wire logic       clock,
  input  wire logic       tied,
  input  wire logic       quad_on,
  input  wire logic       wp_level,
  input  wire logic       hold_level,
  input  wire logic [1:0] io_hi,
  output logic            wp_pin,
  output logic            hold_pin,
  output logic      [3:0] io_pins
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] spin_r = 2'h1;
  // released lines toggle so nothing settles by chance
  always @(posedge clock) spin_r <= ~spin_r;
  // protect pin doubles as io2 in quad transfers
  assign wp_pin   = quad_on ? io_hi[0] : wp_level;
  // a tied hold pin stays at the rail, quad is kept off meanwhile
  assign hold_pin = tied ? 1'h1 : (quad_on ? io_hi[1] : hold_level);
  assign io_pins  = {hold_pin, wp_pin, spin_r};
endmodule
`default_nettype wire

/* File: verif/testbench.sv */
`include "fbwp_regs.vh"
`default_nettype none
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin bad_count++; \
  $display("FAIL t=%0t got %h exp %h", $time, (got), (exp)); end end
// ************************************************************
// register and pin level bench
// ************************************************************
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, reset_n, reg_wr, reg_rd, wp_pin, hold_pin, tied, quad_on, wp_level, hold_level;
  logic        wp_ctrl_low, hold_ctrl_low, io23_oe, op_start, op_refused;
  logic [3:0]  reg_addr, io_pins;
  logic [31:0] reg_wdata, reg_rdata, r;
  logic [1:0]  io_hi, io23_in_data;
  logic [7:0]  op_code;
  logic [35:0] row;
  int          bad_count, checks;
  // rows: pin level, write enable first, opcode, argument, result
  logic [35:0] rows [0:19] = '{
    {1'h1,1'h1,8'h01,24'h000004,2'h1}, {1'h1,1'h1,8'hD8,24'hFFC000,2'h2},
    {1'h1,1'h1,8'hD8,24'hFF8000,2'h1}, {1'h1,1'h1,8'hC7,24'h000000,2'h2},
    {1'h1,1'h0,8'h04,24'h000000,2'h1}, {1'h1,1'h0,8'hC0,24'h000000,2'h1},
    {1'h1,1'h0,8'h17,24'h000000,2'h1}, {1'h1,1'h0,8'h63,24'h000000,2'h2},
    {1'h1,1'h1,8'h01,24'h000028,2'h1}, {1'h1,1'h1,8'h02,24'h800000,2'h2},
    {1'h1,1'h1,8'h20,24'h7FC000,2'h1}, {1'h1,1'h1,8'h01,24'h000034,2'h1},
    {1'h1,1'h1,8'hD8,24'h100000,2'h2}, {1'h1,1'h1,8'hD8,24'h0FC000,2'h1},
    {1'h1,1'h1,8'h01,24'h0000B4,2'h1}, {1'h0,1'h1,8'h01,24'h000000,2'h2},
    {1'h1,1'h0,8'h01,24'h000000,2'h1}, {1'h0,1'h1,8'h01,24'h000008,2'h1},
    {1'h1,1'h1,8'h01,24'h000000,2'h1}, {1'h1,1'h1,8'h60,24'h000000,2'h1}};
  fbwp_protect dut (.clock(clock), .reset_n(reset_n), .clk_en(1'b1), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .wp_pin_in(wp_pin), .hold_pin_in(hold_pin), .io_in(io_pins), .wp_ctrl_low(wp_ctrl_low),
    .hold_ctrl_low(hold_ctrl_low), .io23_oe(io23_oe), .io23_in_data(io23_in_data),
    .op_start(op_start), .op_code(op_code), .op_refused(op_refused));
  fbwp_pin_model host (.clock(clock), .tied(tied), .quad_on(quad_on), .wp_level(wp_level),
    .hold_level(hold_level), .io_hi(io_hi), .wp_pin(wp_pin), .hold_pin(hold_pin),
    .io_pins(io_pins));
  // one-cycle strobes, changed just after the edge
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd   <= 1'b0;
    @(posedge clock);
    d = reg_rdata;
  endtask
  // command then result readback, a zero result is not checked
  task automatic cmd(input logic [7:0] op, input logic [23:0] arg, input logic [1:0] res);
    logic [31:0] q;
    wr(`FBWP_ADDR_COMMAND, {op, arg});
    rd(`FBWP_ADDR_RESULT, q);
    if (res !== 2'h0) `CHK(q[1:0], res)
    `CHK(op_code, op)
  endtask
  task automatic wcmd(input logic [7:0] op, input logic [23:0] arg, input logic [1:0] res);
    cmd(`FBWP_OP_WRITE_ENABLE_CMD, 24'h0, 2'h1);
    cmd(op, arg, res);
  endtask
  task automatic final_report;
    if (bad_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // clock and hang guard
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial begin
    repeat (20000) @(posedge clock);
    bad_count++;
    final_report;
  end
  // main sequence
  initial begin
    {reset_n, reg_wr, reg_rd, quad_on, io_hi, reg_addr, reg_wdata} = '0;
    {tied, wp_level, hold_level} = 3'h7;
    bad_count = 0;
    checks = 0;
    repeat (8) @(posedge clock);
    reset_n <= 1'b1;
    repeat (2) @(posedge clock);
    `CHK(wp_ctrl_low, 1'h0)
    `CHK(hold_ctrl_low, 1'h0)
    rd(`FBWP_ADDR_STATUS, r);
    `CHK(r[7:0], 8'h00)
    rd(`FBWP_ADDR_FUNCTION, r);
    `CHK(r[7:0], 8'h00)
    rd(4'hF, r);
    `CHK(r, 32'h0)
    cmd(`FBWP_OP_WRITE_ENABLE_CMD, 24'h0, 2'h1);
    rd(`FBWP_ADDR_STATUS, r);
    `CHK(r[7:0], 8'h02)
    for (int i = 0; i < 20; i++) begin
      row = rows[i];
      wp_level <= row[35];
      repeat (3) @(posedge clock);
      if (row[34]) cmd(`FBWP_OP_WRITE_ENABLE_CMD, 24'h0, 2'h1);
      cmd(row[33:26], row[25:2], row[1:0]);
    end
    rd(`FBWP_ADDR_STATUS, r);
    `CHK(r[7:0], 8'h00)
    wcmd(8'h01, 24'h000040, 2'h1);
    tied    <= 1'h0;
    quad_on <= 1'h1;
    io_hi   <= 2'h2;
    repeat (4) @(posedge clock);
    `CHK(io23_in_data, 2'h2)
    `CHK(wp_ctrl_low, 1'h0)
    `CHK(io23_oe, 1'h0)
    wcmd(8'h01, 24'h000000, 2'h1);
    quad_on    <= 1'h0;
    wp_level   <= 1'h0;
    hold_level <= 1'h0;
    repeat (4) @(posedge clock);
    `CHK(wp_ctrl_low, 1'h1)
    `CHK(hold_ctrl_low, 1'h1)
    `CHK(io23_in_data, 2'h0)
    {tied, wp_level, hold_level} <= 3'h7;
    wcmd(8'h42, 24'h000002, 2'h1);
    wcmd(8'h01, 24'h000004, 2'h1);
    wcmd(8'hD8, 24'h000000, 2'h2);
    wcmd(8'hD8, 24'h004000, 2'h1);
    wcmd(8'h42, 24'h000000, 2'h0);
    rd(`FBWP_ADDR_FUNCTION, r);
    `CHK(r[7:0], 8'h02)
    wr(`FBWP_ADDR_CONFIG, 32'h1);
    wcmd(8'h01, 24'h000020, 2'h1);
    wcmd(8'hD8, 24'h7F0000, 2'h2);
    wcmd(8'hD8, 24'h800000, 2'h1);
    wcmd(8'h01, 24'h00002C, 2'h1);
    wcmd(8'hD8, 24'hFF0000, 2'h2);
    final_report;
  end
endmodule
`default_nettype wire
